// *** design/pdbc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdbc_consts.svh"
module pdbc_top import pdbc_pkg::*; (
  input wire logic mclk, // 25 MHz clock
  input wire logic rst, // sync reset, active high
  input wire logic power_down_n, // pin, low = power down
  input wire logic self_test_enable, // pin, self-test mode
  input wire logic shared_sel_int_pin, // clock select or interrupt input
  input wire pdbc_gio_cfg_t gio_cfg, // register-side pin config
  input wire pdbc_audio_t audio_in, // alternate function sources
  output logic device_enabled, // device out of power down and internal reset
  output logic logic_reset, // internal reset for other logic
  output logic pll_enable, // PLL running
  output logic self_test_active, // self-test mode
  output logic self_test_clock_select, // 0 pixel, 1 internal
  output logic interrupt_input, // interrupt level when not testing
  output pdbc_gio_drive_t gio_drive // general_io_0..3 out and enable
);
  pdbc_state_t state_reg;
  pdbc_state_t state_next;
  logic pdn_sync;
  logic ste_sync;
  logic shr_sync;
  logic [3:0] pin_out_next;
  logic [3:0] pin_oe_next;
  pdbc_audio_t alt;

  // pins arrive from the host side, so each one passes its own filter
  pdbc_sync3 u_sync_pdn (
    .mclk(mclk),
    .rst(rst),
    .async_in(power_down_n),
    .sync_out(pdn_sync)
  );
  pdbc_sync3 u_sync_ste (
    .mclk(mclk),
    .rst(rst),
    .async_in(self_test_enable),
    .sync_out(ste_sync)
  );
  pdbc_sync3 u_sync_shr (
    .mclk(mclk),
    .rst(rst),
    .async_in(shared_sel_int_pin),
    .sync_out(shr_sync)
  );

  // down -> one cycle of internal reset -> run; any low drops straight to down
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PDBC_ST_DOWN: begin
        if (pdn_sync) begin
          state_next = PDBC_ST_RESET;
        end
      end
      PDBC_ST_RESET: begin
        state_next = pdn_sync ? PDBC_ST_RUN : PDBC_ST_DOWN;
      end
      PDBC_ST_RUN: begin
        if (!pdn_sync) begin
          state_next = PDBC_ST_DOWN;
        end
      end
      default: begin
        state_next = PDBC_ST_DOWN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= PDBC_ST_DOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs follow state_next so they change in the same cycle as the state
  always_ff @(posedge mclk) begin
    if (rst) begin
      device_enabled <= 1'h0;
      pll_enable <= 1'h0;
      logic_reset <= 1'h1;
    end else begin
      device_enabled <= (state_next == PDBC_ST_RUN);
      pll_enable <= (state_next != PDBC_ST_DOWN);
      logic_reset <= (state_next != PDBC_ST_RUN);
    end
  end

  // pin meaning decided by test mode; internal state cleared while not running
  always_ff @(posedge mclk) begin
    if (rst || state_next != PDBC_ST_RUN) begin
      self_test_active <= 1'h0;
      self_test_clock_select <= `PDBC_CLKSEL_PIXEL;
      interrupt_input <= 1'h0;
    end else begin
      self_test_active <= ste_sync;
      self_test_clock_select <= ste_sync ? shr_sync : `PDBC_CLKSEL_PIXEL;
      interrupt_input <= ste_sync ? 1'h0 : shr_sync;
    end
  end

  assign alt = audio_in;
  always_comb begin
    pin_out_next = gio_cfg.gpio_level;
    pin_oe_next = gio_cfg.gpio_oe;
    // alternates are outputs, so the pin is driven whenever selected while running
    if (gio_cfg.alt_sel[0]) begin
      pin_out_next[0] = alt.serial_audio_data_out;
      pin_oe_next[0] = 1'h1;
    end
    if (gio_cfg.alt_sel[1]) begin
      pin_out_next[1] = alt.serial_word_clock;
      pin_oe_next[1] = 1'h1;
    end
    if (gio_cfg.alt_sel[2]) begin
      pin_out_next[2] = alt.audio_data_lane_c;
      pin_oe_next[2] = 1'h1;
    end
    if (gio_cfg.alt_sel[3]) begin
      pin_out_next[3] = alt.audio_data_lane_d;
      pin_oe_next[3] = 1'h1;
    end
  end

  // the reset cycle drives low before register values take over the pins
  always_ff @(posedge mclk) begin
    if (rst || state_next == PDBC_ST_DOWN) begin
      gio_drive.out <= `PDBC_GIO_RESET_LEVEL;
      gio_drive.oe <= `PDBC_GIO_ALL_FLOAT;
    end else if (state_next == PDBC_ST_RESET) begin
      gio_drive.out <= `PDBC_GIO_RESET_LEVEL;
      gio_drive.oe <= `PDBC_GIO_ALL_DRIVE;
    end else begin
      gio_drive.out <= pin_out_next;
      gio_drive.oe <= pin_oe_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_release;
    pdn_sync && state_reg == PDBC_ST_DOWN;
  endsequence
  sequence s_reset_pulse;
    logic_reset && !device_enabled;
  endsequence
  // two running cycles in a row, so the previous inputs were seen while running
  sequence s_steady_run;
    device_enabled && $past(device_enabled);
  endsequence

  AST_RELEASE_RESETS: assert property (s_release |=> s_reset_pulse ##1 (device_enabled || !pdn_sync))
    else $error("release did not pass through reset");

  AST_LOW_POWERS_DOWN: assert property (!pdn_sync |=> !device_enabled && !pll_enable)
    else $error("device enabled while power down low");

  AST_DOWN_TRISTATE: assert property (state_reg == PDBC_ST_DOWN |-> gio_drive.oe == 4'h0 && !pll_enable)
    else $error("outputs driven in power down");

  AST_TEST_FOLLOWS_PIN: assert property (device_enabled && $past(device_enabled) |-> self_test_active == $past(ste_sync))
    else $error("self-test mode does not follow enable");

  AST_CLKSEL_ONLY_TEST: assert property (!self_test_active |-> self_test_clock_select == `PDBC_CLKSEL_PIXEL)
    else $error("clock select used outside self-test");

  AST_INT_MASKED_TEST: assert property (self_test_active |-> !interrupt_input)
    else $error("interrupt seen during self-test");

  AST_RESET_DRIVES_LOW: assert property (state_reg == PDBC_ST_RESET |-> gio_drive.oe == 4'hf && gio_drive.out == 4'h0)
    else $error("general pins not driven low after reset");

  AST_NO_ALT_UNSELECTED: assert property (device_enabled && $past(device_enabled) && $past(gio_cfg.alt_sel) == 4'h0
      |-> gio_drive.out == $past(gio_cfg.gpio_level))
    else $error("alternate function without selection");

  AST_SYNC_DELAY: assert property ($rose(power_down_n) ##1 power_down_n [*3] |-> !device_enabled)
    else $error("release not delayed by synchroniser");

  AST_RESET_STATE_OUTS: assert property (state_reg == PDBC_ST_RESET |-> pll_enable && logic_reset && !device_enabled)
    else $error("reset cycle outputs wrong");

  AST_RUN_STATE_OUTS: assert property (state_reg == PDBC_ST_RUN |-> device_enabled && !logic_reset && pll_enable)
    else $error("run state outputs wrong");

  AST_DOWN_OUT_LOW: assert property (state_reg == PDBC_ST_DOWN |-> gio_drive.out == 4'h0 && logic_reset)
    else $error("power down leaves pin levels or reset wrong");

  AST_PLL_ONLY_ENABLED: assert property (!pll_enable |-> !device_enabled)
    else $error("device enabled with PLL stopped");

  AST_DOWN_NO_TEST: assert property (!device_enabled |-> !self_test_active && !interrupt_input)
    else $error("test mode or interrupt while not running");

  AST_CLKSEL_FOLLOWS_PIN: assert property (s_steady_run ##0 $past(ste_sync)
      |-> self_test_clock_select == $past(shr_sync))
    else $error("clock select does not follow shared pin");

  AST_INT_FOLLOWS_PIN: assert property (s_steady_run ##0 !$past(ste_sync)
      |-> interrupt_input == $past(shr_sync))
    else $error("interrupt does not follow shared pin");

  AST_GPIO_OE_FOLLOWS: assert property (s_steady_run ##0 $past(gio_cfg.alt_sel) == 4'h0
      |-> gio_drive.oe == $past(gio_cfg.gpio_oe))
    else $error("general pin enable does not follow config");

  AST_ALT0_DRIVES: assert property (s_steady_run ##0 $past(gio_cfg.alt_sel[0])
      |-> gio_drive.oe[0] && gio_drive.out[0] == $past(audio_in.serial_audio_data_out))
    else $error("selected alternate not driven");
endmodule : pdbc_top
`default_nettype wire

// *** shared/pdbc_consts.svh ***
`ifndef PDBC_CONSTS_SVH
`define PDBC_CONSTS_SVH
`define PDBC_NUM_GIO 4
`define PDBC_GIO_RESET_LEVEL 4'h0
`define PDBC_GIO_RESET_SEL 4'h0
`define PDBC_GIO_ALL_DRIVE 4'hf
`define PDBC_GIO_ALL_FLOAT 4'h0
`define PDBC_CLKSEL_PIXEL 1'h0
`define PDBC_CLKSEL_INTERNAL 1'h1
`endif

// *** shared/pdbc_pkg.sv ***
package pdbc_pkg;
  typedef enum logic [2:0] {
    PDBC_ST_DOWN = 3'h1,
    PDBC_ST_RESET = 3'h2,
    PDBC_ST_RUN = 3'h4
  } pdbc_state_t;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } pdbc_gio_drive_t;
  typedef struct packed {
    logic [3:0] alt_sel;
    logic [3:0] gpio_level;
    logic [3:0] gpio_oe;
  } pdbc_gio_cfg_t;
  typedef struct packed {
    logic serial_audio_data_out;
    logic serial_word_clock;
    logic audio_data_lane_c;
    logic audio_data_lane_d;
  } pdbc_audio_t;
endpackage : pdbc_pkg

// *** design/pdbc_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdbc_sync3 (
  input wire logic mclk, // clock
  input wire logic rst, // sync reset
  input wire logic async_in, // pin level
  output logic sync_out // filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= 1'h0;
      s2_reg <= 1'h0;
      s3_reg <= 1'h0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // change counted only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_out <= 1'h0;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end
endmodule : pdbc_sync3
`default_nettype wire

// *** dv/pdbc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdbc_host (
  input wire logic mclk, // bench clock
  input wire logic want_on, // host wants the device running
  output logic power_down_n // pin to device
);
  logic [3:0] ramp_reg; // crude supply ramp
  initial ramp_reg = 4'h0;
  initial power_down_n = 1'b0;
  // pin stays low until supplies settle, so a fast request cannot wake a half-powered device
  always @(negedge mclk) begin
    ramp_reg <= want_on ? ((ramp_reg == 4'hf) ? ramp_reg : ramp_reg + 4'h1) : 4'h0;
    power_down_n <= want_on && (ramp_reg == 4'hf);
  end
endmodule : pdbc_host
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top import pdbc_pkg::*;;
  logic mclk = 0, rst = 1, want_on = 0, ste = 0, pin = 0, pdn;
  logic en, lrst, pll, sta, csel, intr;
  pdbc_gio_cfg_t cfg = '0;
  pdbc_audio_t aud = '0;
  pdbc_gio_drive_t gd;
  int err_count = 0, num_checks = 0;
  logic [31:0] rnd = 32'h419e038d;
  logic [13:0] q[$];
  event ev;
  always #20 mclk = ~mclk;
  pdbc_host i_host (.mclk(mclk), .want_on(want_on), .power_down_n(pdn));
  pdbc_top i_dut (.mclk(mclk), .rst(rst), .power_down_n(pdn), .self_test_enable(ste),
    .shared_sel_int_pin(pin), .gio_cfg(cfg), .audio_in(aud), .device_enabled(en),
    .logic_reset(lrst), .pll_enable(pll), .self_test_active(sta),
    .self_test_clock_select(csel), .interrupt_input(intr), .gio_drive(gd));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [13:0] exp_run();
    logic [3:0] ab, oe;
    ab = {aud.audio_data_lane_d, aud.audio_data_lane_c, aud.serial_word_clock, aud.serial_audio_data_out};
    oe = cfg.alt_sel | cfg.gpio_oe;
    return {1'b0, 2'h3, ste, ste & pin, ~ste & pin, (cfg.alt_sel & ab | ~cfg.alt_sel & cfg.gpio_level) & oe, oe};
  endfunction : exp_run
  task check(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task note(input logic [13:0] e);
    q.push_back(e);
    ->ev;
  endtask : note
  task wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // pin levels are compared only where a pin is driven; an undriven level means nothing
  always @(ev) begin
    #1;
    check({lrst, en, pll, sta, csel, intr, gd.out & gd.oe, gd.oe}, q.pop_front());
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst = 0;
    repeat (4) @(negedge mclk);
    note(14'h2000);
    $display("test power_down done");
    for (int p = 0; p < 2; p++) begin
      want_on = 1;
      for (int i = 0; i < 60 && pll !== 1'b1; i++) @(negedge mclk);
      note(14'h280f);
      for (int i = 0; i < 12; i++) begin
        rnd = lfsr(rnd);
        {ste, pin} = rnd[1:0];
        cfg = rnd[13:2];
        if (i == 0) cfg.alt_sel = 4'h0;
        aud = rnd[17:14];
        repeat (8) @(negedge mclk);
        note(exp_run());
      end
      want_on = 0;
      repeat (8) @(negedge mclk);
      note(14'h2000);
      $display("test cycle %0d done", p);
    end
    repeat (2) @(negedge mclk);
    wrap_up();
  end
  initial begin
    #(40 * 1000);
    err_count++;
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
